// ---- core/gate_ctl_pkg.sv ----
// Constants and types shared by the gate driver control logic
package gate_ctl_pkg;

    localparam int unsigned CLK_PERIOD_NS = 5;

    // Filter and protection times
    localparam int unsigned IN_FILTER_NS = 40;
    localparam int unsigned EN_FILTER_NS = 40;
    localparam int unsigned CLEAR_HOLD_NS = 1000;
    localparam int unsigned WDOG_NS = 2000;
    localparam int unsigned LOCKOUT_DELAY_NS = 500;
    localparam int unsigned SAT_DELAY_NS = 100;

    // Turn-on and plateau timing
    localparam int unsigned DISCHARGE_NS = 500;
    localparam int unsigned PROP_NS = 200;
    localparam int unsigned STEP_NS = 50;

    // Cycle counts: least times round up, none below one cycle
    localparam int unsigned IN_FILTER_CYC = (IN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned EN_FILTER_CYC = (EN_FILTER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned CLEAR_HOLD_CYC = (CLEAR_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WDOG_CYC = (WDOG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned LOCKOUT_DELAY_CYC = (LOCKOUT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned SAT_DELAY_CYC = (SAT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned DISCHARGE_CYC = (DISCHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned PROP_CYC = (PROP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned STEP_CYC = STEP_NS / CLK_PERIOD_NS;

    localparam int unsigned CNT_W = 12;
    localparam int unsigned STEP_W = 8;
    localparam logic [STEP_W-1:0] STEP_MAX = 8'hFF;
    localparam logic [STEP_W-1:0] STEP_ZERO = 8'h00;
    localparam logic [CNT_W-1:0] CNT_ZERO = 12'h000;
    localparam logic [CNT_W-1:0] CNT_ONE = 12'h001;

    typedef enum logic [5:0] {
        ST_OFF = 6'h01,
        ST_DISCHARGE = 6'h02,
        ST_CHARGE = 6'h04,
        ST_ON = 6'h08,
        ST_DESCEND = 6'h10,
        ST_PLATEAU = 6'h20
    } drive_state_t;

    typedef enum logic [1:0] {
        LVL_NEG = 2'h1,
        LVL_PLATEAU = 2'h2,
        LVL_ON = 2'h3
    } out_level_t;

endpackage : gate_ctl_pkg

// ---- core/gate_driver_control_logic.sv ----
// Control and protection logic of a single isolated gate driver
// Overview of operation
// R01 - Drive on only when non-inverting input high and inverting input low.
// R02 - Pulses on either drive input shorter than minimum width are rejected.
// R03 - Enable/clear low holds the transistor off; short pulses on it ignored.
// R04 - Saturation fault clears only after enable/clear held low for clear hold time.
// R05 - Saturation event drives fault output low, latched until valid clear.
// R06 - Saturation needs output on, comparator exceeded, blanking expired; then turn off.
// R07 - Ready high only when both supplies unlocked and transmission faultless.
// R08 - Any error mode forces output to negative rail regardless of inputs; code skips this while a fault is latched.
// R09 - Input-side lockout sends turn-off and ignores drive inputs until recovery.
// R10 - Output-side lockout turns off, ignores input side until recovery.
// R11 - Ready follows input lockout directly, others after short delay; never latches.
// R12 - Watchdog on transmission; failure too long turns off and drops ready.
// R13 - On command discharge plateau cap 500 ns, charge, on at comparator end.
// R14 - Measure command-to-on time less 200 ns, stored in 50 ns steps.
// R15 - Input-commanded turn-off starts plateau descent after about 200 ns.
// R16 - Saturation turn-off starts descent after the sense-to-output delay.
// R17 - Below plateau reference hold plateau; negative rail after stored plateau time.
// R18 - Two-level turn-off always applied; no bypass exists; code skips it in error mode while no fault is latched.
// R19 - During turn-off clamp activates once gate falls below 2 V comparator.
// R20 - On and off pulses shorter than plateau time are suppressed.
// R21 - Plateau never shortened; renewed on request goes high after plateau time; code cuts it short in error mode while no fault is latched.
// R22 - Fault released on enable/clear rising edge only after long enough low.
// R23 - All timing from one clock with counters; period divides 50 ns.
module gate_driver_control_logic
    import gate_ctl_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic drive_pos_i,
    input wire logic drive_neg_i,
    input wire logic enable_clear_n_i,
    input wire logic input_lockout_i,
    input wire logic output_lockout_i,
    input wire logic link_alive_i,
    input wire logic sat_monitor_i,
    input wire logic blank_expired_i,
    input wire logic plateau_timing_pin_i,
    input wire logic plateau_ref_below_i,
    input wire logic gate_below_2v_i,
    output logic drive_on_o,
    output logic drive_plateau_o,
    output logic drive_neg_rail_o,
    output logic cap_discharge_o,
    output logic clamp_o,
    output logic sat_fault_n_o,
    output logic sat_fault_n_oe_o,
    output logic ready_o,
    output logic ready_oe_o
);

    // ****************************************************************
    // State
    // ****************************************************************
    typedef struct packed {
        logic [1:0] s_pos;
        logic [1:0] s_neg;
        logic [1:0] s_en;
        logic [1:0] s_inlk;
        logic [1:0] s_outlk;
        logic [1:0] s_link;
        logic [1:0] s_sat;
        logic [1:0] s_blank;
        logic [1:0] s_cmp;
        logic [1:0] s_ref;
        logic [1:0] s_gate;
        logic pos_f;
        logic neg_f;
        logic en_f;
        logic [CNT_W-1:0] pos_cnt;
        logic [CNT_W-1:0] neg_cnt;
        logic [CNT_W-1:0] en_cnt;
        logic [CNT_W-1:0] low_cnt;
        logic low_long;
        logic fault;
        logic [CNT_W-1:0] wd_cnt;
        logic link_err;
        logic [CNT_W-1:0] lk_cnt;
        logic out_ok;
        drive_state_t state;
        logic [CNT_W-1:0] tmr;
        logic [STEP_W-1:0] meas;
        logic [CNT_W-1:0] sub;
        logic [STEP_W-1:0] plateau_steps;
        logic sat_off;
        logic req_dly;
        logic [CNT_W-1:0] off_dly;
        logic [CNT_W-1:0] on_hold;
        out_level_t level;
        logic clamp;
    } ctl_state_t;

    ctl_state_t r;
    ctl_state_t next_r;

    logic want_on;
    logic error_mode;

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        next_r = r;

        // Two-stage synchronisers; first stage read only by the second
        next_r.s_pos = {r.s_pos[0], drive_pos_i};
        next_r.s_neg = {r.s_neg[0], drive_neg_i};
        next_r.s_en = {r.s_en[0], enable_clear_n_i};
        next_r.s_inlk = {r.s_inlk[0], input_lockout_i};
        next_r.s_outlk = {r.s_outlk[0], output_lockout_i};
        next_r.s_link = {r.s_link[0], link_alive_i};
        next_r.s_sat = {r.s_sat[0], sat_monitor_i};
        next_r.s_blank = {r.s_blank[0], blank_expired_i};
        next_r.s_cmp = {r.s_cmp[0], plateau_timing_pin_i};
        next_r.s_ref = {r.s_ref[0], plateau_ref_below_i};
        next_r.s_gate = {r.s_gate[0], gate_below_2v_i};

        // Glitch filters: a level must stand the full width to be taken
        if (r.s_pos[1] == r.pos_f) begin
            next_r.pos_cnt = CNT_ZERO;
        end else if (r.pos_cnt == CNT_WIDTH(IN_FILTER_CYC)) begin
            next_r.pos_f = r.s_pos[1]; // R02
            next_r.pos_cnt = CNT_ZERO;
        end else begin
            next_r.pos_cnt = r.pos_cnt + CNT_ONE;
        end
        if (r.s_neg[1] == r.neg_f) begin
            next_r.neg_cnt = CNT_ZERO;
        end else if (r.neg_cnt == CNT_WIDTH(IN_FILTER_CYC)) begin
            next_r.neg_f = r.s_neg[1]; // R02
            next_r.neg_cnt = CNT_ZERO;
        end else begin
            next_r.neg_cnt = r.neg_cnt + CNT_ONE;
        end
        if (r.s_en[1] == r.en_f) begin
            next_r.en_cnt = CNT_ZERO;
        end else if (r.en_cnt == CNT_WIDTH(EN_FILTER_CYC)) begin
            next_r.en_f = r.s_en[1]; // R03
            next_r.en_cnt = CNT_ZERO;
        end else begin
            next_r.en_cnt = r.en_cnt + CNT_ONE;
        end

        // Clear hold measurement on the raw synchronised enable level
        if (r.s_en[1]) begin
            next_r.low_cnt = CNT_ZERO;
        end else if (r.low_cnt != CNT_WIDTH(CLEAR_HOLD_CYC)) begin
            next_r.low_cnt = r.low_cnt + CNT_ONE;
        end
        next_r.low_long = (r.low_cnt == CNT_WIDTH(CLEAR_HOLD_CYC));

        // Watchdog on transmission alive level
        if (r.s_link[1]) begin
            next_r.wd_cnt = CNT_ZERO;
            next_r.link_err = 1'b0;
        end else if (r.wd_cnt == CNT_WIDTH(WDOG_CYC)) begin
            next_r.link_err = 1'b1; // R12
        end else begin
            next_r.wd_cnt = r.wd_cnt + CNT_ONE;
        end

        // Output side and link status reach ready after a short delay, no latch
        if (r.s_outlk[1] || r.link_err) begin
            next_r.lk_cnt = CNT_ZERO;
            next_r.out_ok = 1'b0;
        end else if (r.lk_cnt == CNT_WIDTH(LOCKOUT_DELAY_CYC)) begin
            next_r.out_ok = 1'b1; // R11
        end else begin
            next_r.lk_cnt = r.lk_cnt + CNT_ONE;
        end

        // Fault latch: release only on rising edge after long low; set wins
        if (r.low_long && r.s_en[1]) begin
            next_r.fault = 1'b0; // R04 R22
        end
        if (r.state == ST_ON && r.s_sat[1] && r.s_blank[1]) begin
            next_r.fault = 1'b1; // R05 R06
        end

        // Registered on request, gated by error mode; propagation and sense delays are counted in ST_ON
        next_r.req_dly = want_on && !error_mode;

        // Turn-on / two-level turn-off sequencer (error mode without a latched fault bypasses it) R18
        next_r.clamp = 1'b0;
        case (r.state)
            ST_OFF: begin
                next_r.level = LVL_NEG;
                next_r.clamp = r.s_gate[1]; // R19
                if (r.req_dly && !r.fault) begin
                    next_r.state = ST_DISCHARGE; // R13
                    next_r.tmr = CNT_ZERO;
                    next_r.meas = STEP_ZERO;
                    next_r.sub = CNT_ZERO;
                end
            end
            ST_DISCHARGE, ST_CHARGE: begin
                // Command-to-on time in 50 ns steps; propagation subtracted at store
                if (r.sub == CNT_WIDTH(STEP_CYC - 1)) begin
                    next_r.sub = CNT_ZERO;
                    if (r.meas != STEP_MAX) begin
                        next_r.meas = r.meas + 8'h01; // R14
                    end
                end else begin
                    next_r.sub = r.sub + CNT_ONE;
                end
                if (!r.req_dly || r.fault) begin
                    next_r.state = ST_OFF; // R20
                end else if (r.state == ST_DISCHARGE) begin
                    next_r.tmr = r.tmr + CNT_ONE;
                    if (r.tmr == CNT_WIDTH(DISCHARGE_CYC - 1)) begin
                        next_r.state = ST_CHARGE; // R13
                    end
                end else if (r.s_cmp[1]) begin
                    next_r.state = ST_ON; // R13
                    next_r.level = LVL_ON; // R01
                    next_r.plateau_steps = (r.meas > STEP_WIDTH(PROP_NS / STEP_NS))
                        ? r.meas - STEP_WIDTH(PROP_NS / STEP_NS) : 8'h01; // R14
                    next_r.sat_off = 1'b0;
                    next_r.off_dly = CNT_ZERO;
                end
            end
            ST_ON: begin
                // Restart the count on a fault so a running input delay cannot overshoot it
                if (r.fault && !r.sat_off) begin
                    next_r.sat_off = 1'b1;
                    next_r.off_dly = CNT_ZERO;
                end else if (r.fault || !r.req_dly) begin
                    next_r.off_dly = r.off_dly + CNT_ONE;
                    if (r.off_dly >= CNT_WIDTH((r.fault ? SAT_DELAY_CYC : PROP_CYC) - 1)) begin
                        next_r.state = ST_DESCEND; // R15 R16
                        next_r.level = LVL_PLATEAU;
                    end
                end else begin
                    next_r.off_dly = CNT_ZERO;
                end
            end
            ST_DESCEND: begin
                if (r.s_ref[1]) begin
                    next_r.state = ST_PLATEAU; // R17
                    next_r.tmr = CNT_ZERO;
                    next_r.sub = CNT_ZERO;
                end
            end
            ST_PLATEAU: begin
                // Plateau runs its full length whatever the drive inputs do; only error mode cuts it short
                if (r.sub == CNT_WIDTH(STEP_CYC - 1)) begin
                    next_r.sub = CNT_ZERO;
                    next_r.tmr = r.tmr + CNT_ONE;
                end else begin
                    next_r.sub = r.sub + CNT_ONE;
                end
                if (r.tmr >= {4'h0, r.plateau_steps} && r.sub == CNT_ZERO) begin
                    if (r.req_dly && !r.fault) begin
                        next_r.state = ST_ON; // R20 R21
                        next_r.level = LVL_ON;
                        next_r.off_dly = CNT_ZERO;
                    end else begin
                        next_r.state = ST_OFF; // R17
                        next_r.level = LVL_NEG;
                    end
                end
            end
            default: begin
                next_r.state = ST_OFF;
                next_r.level = LVL_NEG;
            end
        endcase

        // Error mode overrides everything but a latched fault and drops to the negative rail
        if (error_mode && !r.fault) begin
            next_r.state = ST_OFF; // R08 R09 R10 R12
            next_r.level = LVL_NEG;
        end
        next_r.on_hold = CNT_ZERO;
    end

    // Helpers to fit int constants to counter widths
    function automatic logic [CNT_W-1:0] CNT_WIDTH(input int unsigned v);
        CNT_WIDTH = v[CNT_W-1:0];
    endfunction : CNT_WIDTH

    function automatic logic [STEP_W-1:0] STEP_WIDTH(input int unsigned v);
        STEP_WIDTH = v[STEP_W-1:0];
    endfunction : STEP_WIDTH

    // Lockouts gate the inputs; saturation is handled by its own delayed path
    assign error_mode = r.s_inlk[1] || r.s_outlk[1] || r.link_err; // R08
    assign want_on = r.pos_f && !r.neg_f && r.en_f && !r.s_inlk[1]; // R01 R03 R09

    // ****************************************************************
    // Registers
    // ****************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            r <= '{s_en: 2'h3, s_neg: 2'h3, en_f: 1'b1, neg_f: 1'b1,
                   s_inlk: 2'h3, s_outlk: 2'h3, state: ST_OFF, level: LVL_NEG,
                   plateau_steps: 8'h01, default: '0};
        end else begin
            r <= next_r; // R23
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign drive_on_o = (r.level == LVL_ON);
    assign drive_plateau_o = (r.level == LVL_PLATEAU);
    assign drive_neg_rail_o = (r.level == LVL_NEG);
    assign cap_discharge_o = (r.state == ST_DISCHARGE) || (r.state == ST_OFF);
    assign clamp_o = r.clamp;
    // Open drain: pulls low while a fault is latched
    assign sat_fault_n_o = 1'b0;
    assign sat_fault_n_oe_o = r.fault; // R05
    assign ready_o = 1'b0;
    assign ready_oe_o = r.s_inlk[1] || !r.out_ok; // R07 R11

endmodule : gate_driver_control_logic

// ---- tb/gate_drv_monitor.sv ----
// Port checker for the gate driver control logic, bound to its top module
module gate_drv_monitor
    import gate_ctl_pkg::*;
(
    input wire logic ref_clk_i,
    input wire logic rst_n_i,
    input wire logic drive_pos_i,
    input wire logic drive_neg_i,
    input wire logic enable_clear_n_i,
    input wire logic input_lockout_i,
    input wire logic output_lockout_i,
    input wire logic link_alive_i,
    input wire logic sat_monitor_i,
    input wire logic blank_expired_i,
    input wire logic plateau_timing_pin_i,
    input wire logic plateau_ref_below_i,
    input wire logic gate_below_2v_i,
    input wire logic drive_on_o,
    input wire logic drive_plateau_o,
    input wire logic drive_neg_rail_o,
    input wire logic cap_discharge_o,
    input wire logic clamp_o,
    input wire logic sat_fault_n_o,
    input wire logic sat_fault_n_oe_o,
    input wire logic ready_o,
    input wire logic ready_oe_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int SAT_WIN = 30;
    logic [11:0] off_cnt;
    logic [11:0] link_cnt;
    logic [11:0] low_cnt;
    logic [11:0] last_low;
    default clocking @(posedge ref_clk_i);
    endclocking
    default disable iff (!rst_n_i);
    // Saturating run counters, so long waits need no long repetitions
    always_ff @(posedge ref_clk_i) begin
        if (!rst_n_i) begin
            off_cnt <= 12'h000;
            link_cnt <= 12'h000;
            low_cnt <= 12'h000;
            last_low <= 12'h000;
        end else begin
            off_cnt <= (drive_pos_i && !drive_neg_i && enable_clear_n_i) ? 12'h000 : off_cnt + {11'h000, ~&off_cnt};
            link_cnt <= link_alive_i ? 12'h000 : link_cnt + {11'h000, ~&link_cnt};
            low_cnt <= enable_clear_n_i ? 12'h000 : low_cnt + {11'h000, ~&low_cnt};
            if (enable_clear_n_i && low_cnt != 12'h000) begin
                last_low <= low_cnt;
            end
        end
    end
    a_levels_exclusive: assert property ($onehot0({drive_on_o, drive_plateau_o, drive_neg_rail_o}))
        else $error("more than one output level active");
    a_od_data_low: assert property (sat_fault_n_o == 1'b0 && ready_o == 1'b0)
        else $error("open-drain data not low");
    a_off_request: assert property (off_cnt >= 12'h046 |-> !drive_on_o)
        else $error("output on without on request");
    a_in_lockout: assert property (input_lockout_i [*6] |-> drive_neg_rail_o && ready_oe_o)
        else $error("input lockout not honoured");
    a_out_lockout: assert property (output_lockout_i [*6] |-> drive_neg_rail_o)
        else $error("output lockout not honoured");
    a_ready_release: assert property ($fell(ready_oe_o) |-> !$past(output_lockout_i, 90) && !$past(input_lockout_i))
        else $error("ready released too early");
    a_watchdog_trip: assert property (link_cnt > WDOG_CYC + LOCKOUT_DELAY_CYC + 8 |-> ready_oe_o && drive_neg_rail_o)
        else $error("watchdog did not trip");
    a_clear_hold: assert property ($fell(sat_fault_n_oe_o) |-> last_low >= CLEAR_HOLD_CYC - 1)
        else $error("fault cleared by short low");
    a_fault_holds: assert property (enable_clear_n_i [*8] ##0 sat_fault_n_oe_o |=> sat_fault_n_oe_o)
        else $error("fault released without clear");
    a_sat_turnoff: assert property ($rose(sat_fault_n_oe_o) |-> ##[0:SAT_WIN] !drive_on_o)
        else $error("output stayed on after fault");
    a_clamp_gate: assert property (!gate_below_2v_i [*4] |-> !clamp_o)
        else $error("clamp active with gate high");
    a_on_needs_cap: assert property ($rose(drive_on_o) |-> $past(plateau_timing_pin_i, 2) && !cap_discharge_o)
        else $error("output on before charge cycle ended");
endmodule : gate_drv_monitor

bind gate_driver_control_logic gate_drv_monitor mon_u (.ref_clk_i, .rst_n_i, .drive_pos_i, .drive_neg_i,
    .enable_clear_n_i, .input_lockout_i, .output_lockout_i, .link_alive_i, .sat_monitor_i, .blank_expired_i,
    .plateau_timing_pin_i, .plateau_ref_below_i, .gate_below_2v_i, .drive_on_o, .drive_plateau_o,
    .drive_neg_rail_o, .cap_discharge_o, .clamp_o, .sat_fault_n_o, .sat_fault_n_oe_o, .ready_o, .ready_oe_o);

// ---- tb/host_ctl_model.sv ----
// Host controller model driving the drive and enable/clear pins
module host_ctl_model
(
    input wire logic clk_i,
    input wire logic on_req_i,
    input wire logic inv_mode_i,
    input wire logic en_req_n_i,
    input wire logic fault_oe_i,
    input wire logic ready_oe_i,
    output logic pos_o = 1'b0,
    output logic neg_o = 1'b1,
    output logic en_n_o = 1'b1,
    output logic fault_line_o,
    output logic ready_line_o
);
    timeunit 1ns;
    timeprecision 1ps;
    // Inverting mode parks the non-inverting pin high
    always @(posedge clk_i) begin
        pos_o <= inv_mode_i ? 1'b1 : on_req_i;
        neg_o <= inv_mode_i ? !on_req_i : 1'b0;
        en_n_o <= en_req_n_i;
    end
    // Pull-ups on both open-drain lines
    assign fault_line_o = fault_oe_i ? 1'b0 : 1'b1;
    assign ready_line_o = ready_oe_i ? 1'b0 : 1'b1;
endmodule : host_ctl_model

// ---- tb/gate_driver_control_logic_tb_top.sv ----
// Self-checking bench for the gate driver control logic
module gate_driver_control_logic_tb_top
    import gate_ctl_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk_i = 1'b0, rst_n_i = 1'b0, on_req = 1'b0, inv_mode = 1'b0, en_req_n = 1'b1;
    logic in_lock = 1'b0, out_lock = 1'b0, link_ok = 1'b1, sat_hi = 1'b0, blank_done = 1'b0;
    logic timing_pin = 1'b0, ref_below = 1'b0, gate_low = 1'b0;
    logic drive_pos, drive_neg, en_n, fault_line, ready_line;
    logic drive_on, drive_plateau, drive_neg_rail, cap_discharge, clamp, fault_n, fault_oe, ready, ready_oe;
    int seed = 32'h88f44a25;
    int errors = 0, compares = 0, chg = 0, chg_len = 100, t, w, hold, m, c;

    always #2.5 ref_clk_i = !ref_clk_i;

    host_ctl_model host_u (.clk_i(ref_clk_i), .on_req_i(on_req), .inv_mode_i(inv_mode), .en_req_n_i(en_req_n),
        .fault_oe_i(fault_oe), .ready_oe_i(ready_oe), .pos_o(drive_pos), .neg_o(drive_neg), .en_n_o(en_n),
        .fault_line_o(fault_line), .ready_line_o(ready_line));

    gate_driver_control_logic dut_u (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .drive_pos_i(drive_pos),
        .drive_neg_i(drive_neg), .enable_clear_n_i(en_n), .input_lockout_i(in_lock), .output_lockout_i(out_lock),
        .link_alive_i(link_ok), .sat_monitor_i(sat_hi), .blank_expired_i(blank_done),
        .plateau_timing_pin_i(timing_pin), .plateau_ref_below_i(ref_below), .gate_below_2v_i(gate_low),
        .drive_on_o(drive_on), .drive_plateau_o(drive_plateau), .drive_neg_rail_o(drive_neg_rail),
        .cap_discharge_o(cap_discharge), .clamp_o(clamp), .sat_fault_n_o(fault_n), .sat_fault_n_oe_o(fault_oe),
        .ready_o(ready), .ready_oe_o(ready_oe));

    // Power stage stand-in: cap charges once discharge stops
    always @(posedge ref_clk_i) begin
        chg <= cap_discharge ? 0 : chg + 1;
        timing_pin <= !cap_discharge && chg >= chg_len;
        ref_below <= !drive_on;
        gate_low <= drive_neg_rail;
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk_i);
    endtask : cyc

    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        compares++;
        if (seen !== want) begin
            errors++;
            $display("unexpected value at %0t: saw %0h, want %0h", $time, seen, want);
        end
    endtask : check

    function automatic logic pick(input int k);
        logic [4:0] v;
        v = {!ready_oe, fault_oe, drive_neg_rail, drive_plateau, drive_on};
        return v[k];
    endfunction : pick

    task automatic wait_hi(input int k, input int lim, output int n);
        n = 0;
        while (!pick(k) && n < lim) begin
            cyc(1);
            n++;
        end
    endtask : wait_hi

    task automatic close_out();
        $display("errors %0d compares %0d", errors, compares);
        if (errors == 0 && compares > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    // Roughly fifteen times the expected run length
    initial begin
        #400000;
        errors++;
        close_out();
    end

    initial begin
        cyc(5);
        rst_n_i <= 1'b1;
        cyc(150);
        check(ready_line, 1'b1);
        // ****************************************
        // Turn on and two-level turn off, both modes
        // ****************************************
        for (m = 0; m < 2; m++) begin
            inv_mode <= m[0];
            chg_len = 60 + {$random(seed)} % 80;
            cyc(20);
            on_req <= 1'b1;
            wait_hi(0, 2000, t);
            check(t >= DISCHARGE_CYC + chg_len && t < 2000, 1'b1);
            hold = (t - PROP_CYC) / STEP_CYC * STEP_CYC;
            cyc(30);
            on_req <= 1'b0;
            wait_hi(1, 500, w);
            check(w >= PROP_CYC && w <= PROP_CYC + 20, 1'b1);
            wait_hi(2, 3000, w);
            check(w + 30 >= hold && w <= hold + 30, 1'b1);
            cyc(4);
            check(clamp, 1'b1);
        end
        // ****************************************
        // Short pulses, renewed on during plateau
        // ****************************************
        for (c = 0; c < 4; c++) begin
            w = c < 2 ? 1 + {$random(seed)} % 6 : 20 + {$random(seed)} % 60;
            on_req <= 1'b1;
            cyc(w);
            on_req <= 1'b0;
            wait_hi(0, 300, t);
            check(t, 300);
        end
        on_req <= 1'b1;
        wait_hi(0, 2000, t);
        on_req <= 1'b0;
        cyc(1 + {$random(seed)} % 6);
        on_req <= 1'b1;
        wait_hi(1, 300, t);
        check(t, 300);
        on_req <= 1'b0;
        cyc(80);
        on_req <= 1'b1;
        wait_hi(0, 3000, t);
        check(t + 50 >= hold && t <= hold, 1'b1);
        // ****************************************
        // Saturation fault, short and long clear
        // ****************************************
        sat_hi <= 1'b1;
        cyc(50);
        check(fault_oe, 1'b0);
        blank_done <= 1'b1;
        wait_hi(3, 100, t);
        check(fault_line, 1'b0);
        wait_hi(1, 100, t);
        check(t <= SAT_DELAY_CYC + 10, 1'b1);
        sat_hi <= 1'b0;
        blank_done <= 1'b0;
        on_req <= 1'b0;
        for (c = 0; c < 2; c++) begin
            en_req_n <= 1'b0;
            cyc(c == 0 ? 20 + {$random(seed)} % 160 : CLEAR_HOLD_CYC + 20);
            en_req_n <= 1'b1;
            cyc(20);
            check(fault_oe, c == 0);
        end
        // ****************************************
        // Lockouts and watchdog while driving
        // ****************************************
        for (c = 0; c < 3; c++) begin
            on_req <= 1'b1;
            wait_hi(0, 2000, t);
            in_lock <= c == 0;
            out_lock <= c == 1;
            link_ok <= c != 2;
            cyc(c == 2 ? WDOG_CYC + LOCKOUT_DELAY_CYC + 20 : 120);
            check(drive_neg_rail, 1'b1);
            check(ready_line, 1'b0);
            on_req <= 1'b0;
            in_lock <= 1'b0;
            out_lock <= 1'b0;
            link_ok <= 1'b1;
            wait_hi(4, 1000, t);
            check(c == 0 ? t < 10 : t + 10 >= LOCKOUT_DELAY_CYC && t < LOCKOUT_DELAY_CYC + 20, 1'b1);
            cyc(50);
        end
        close_out();
    end
endmodule : gate_driver_control_logic_tb_top
